//--- inc/cse_defs.svh
// constants for the capacitive sense external-control block
`ifndef CSE_DEFS_SVH
`define CSE_DEFS_SVH
`define CSE_CLK_HZ          50000000
`define CSE_TICK_HZ         1000
`define CSE_TICK_CYC        (`CSE_CLK_HZ / `CSE_TICK_HZ)
`define CSE_SHORT_MIN_MS    15
`define CSE_SHORT_MAX_MS    25
`define CSE_HALT_MIN_MS     50
`define CSE_PROX_ADD        4
`define CSE_ACT_ADD         10
`define CSE_SENSITIVITY_SCAN_CONFIG_BANK_RST       8'h00
`define CSE_B0_BASE_HI      7
`define CSE_B0_BASE_LO      6
`define CSE_B0_SCAN_HI      5
`define CSE_B0_SCAN_LO      4
`define CSE_B0_WAKE         3
`define CSE_SIG_PULSES      3
`define CSE_SIG_HALF_MS     2
`define CSE_CAP_TRIP        16'h0FFF
`define CSE_CNT_W           16
`endif

//--- inc/cse_pkg.sv
// types for the capacitive sense external-control block
package cse_pkg;
  typedef enum logic [1:0] {CSE_UI_ACTIVATION_MOVEMENT_INTERFACE, CSE_UI_MOVEMENT_INPUT_INTERFACE, CSE_UI_OTHER} cse_ui_t;
  typedef enum logic [1:0] {CSE_COM_I2C, CSE_COM_DIRECT, CSE_COM_STREAM} cse_com_t;
  typedef enum logic [1:0] {CSE_M_IDLE, CSE_M_XFER, CSE_M_DONE} cse_meas_t;
  typedef struct packed {
    logic [1:0] base_sel;
    logic [1:0] scan_sel;
    logic       wake_both;
    logic [2:0] sleep_sel;
  } cse_sensitivity_scan_config_bank_t;
  typedef struct packed {
    logic [15:0] counts;
    logic [15:0] long_term_average;
    logic [7:0]  prox_th;
    logic [7:0]  act_th;
    logic [7:0]  mov_th;
    logic        ac_double;
  } cse_sense_t;
endpackage : cse_pkg

//--- src/cse_pulse_timer.sv
// low-pulse timer on the multifunction pin or the sampled activation pin, using a millisecond tick
`timescale 1ns/1ps
`default_nettype none
`include "cse_defs.svh"
module cse_pulse_timer #(
  parameter int TICK_CYC = `CSE_TICK_CYC
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // pin sample
  input  wire logic       pin_low,
  input  wire logic       sample_en,
  // results
  output logic            short_pulse,
  output logic            halt_enter,
  output logic            halt_release
);
  typedef struct packed {
    logic [31:0] tick;
    logic [7:0]  ms;
    logic        halted;
    logic        shortp;
    logic        henter;
    logic        hrel;
  } cse_pt_state_t;
  cse_pt_state_t st_reg;
  cse_pt_state_t st_next;
  always_comb
  begin
    st_next        = st_reg;
    st_next.shortp = 1'b0;
    st_next.henter = 1'b0;
    st_next.hrel   = 1'b0;
    if (sample_en && pin_low)
    begin
      // count whole milliseconds while low
      if (st_reg.tick == 32'(TICK_CYC - 1))
      begin
        st_next.tick = '0;
        if (st_reg.ms != 8'hFF)
          st_next.ms = st_reg.ms + 8'h01;
        if (st_reg.ms + 8'h01 == 8'(`CSE_HALT_MIN_MS) && !st_reg.halted)
        begin
          st_next.halted = 1'b1;
          st_next.henter = 1'b1;
        end
      end
      else
        st_next.tick = st_reg.tick + 32'h1;
    end
    else
    begin
      // pulse ended: classify by length, others ignored
      if (st_reg.halted)
        st_next.hrel = 1'b1;
      else if (st_reg.ms > 8'(`CSE_SHORT_MIN_MS) && st_reg.ms < 8'(`CSE_SHORT_MAX_MS))
        st_next.shortp = 1'b1;
      st_next.tick   = '0;
      st_next.ms     = '0;
      st_next.halted = 1'b0;
    end
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  assign short_pulse  = st_reg.shortp;
  assign halt_enter   = st_reg.henter;
  assign halt_release = st_reg.hrel;
endmodule : cse_pulse_timer
`default_nettype wire

//--- src/cse_ext_ctrl.sv
// external control, mode handoff, measurement and tuning of the sensor
`timescale 1ns/1ps
`default_nettype none
`include "cse_defs.svh"
module cse_ext_ctrl
  import cse_pkg::*;
#(
  parameter int TICK_CYC = `CSE_TICK_CYC,
  parameter int SAMPLE_PERIOD = 64
) (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // configuration
  input  wire cse_pkg::cse_ui_t   ui_sel,
  input  wire cse_pkg::cse_com_t  com_target,
  input  wire logic               cfg_switch_en,
  input  wire logic               input_feature_en,
  input  wire logic               input_is_reduce,
  input  wire logic               partial_tune_en,
  input  wire logic [15:0]        tune_target,
  input  wire logic [7:0]         prox_th_cfg,
  input  wire logic [7:0]         act_th_cfg,
  input  wire logic [7:0]         mov_th_cfg,
  // configuration register access
  input  wire logic               cfg_wr,
  input  wire logic [7:0]         cfg_wdata,
  output logic [7:0]              cfg_rdata,
  input  wire logic               i2c_window_close,
  // multifunction pin and activation pin
  input  wire logic               multifunction_pin_in,
  input  wire logic               activation_output_in,
  output logic                    activation_output,
  output logic                    activation_output_oe,
  output logic                    multifunction_pin_out,
  output logic                    multifunction_pin_oe,
  // sensing
  input  wire logic               activation_det,
  input  wire logic               event_active,
  input  wire logic               stream_bit,
  input  wire logic [15:0]        transfer_charge,
  // status
  output cse_pkg::cse_sense_t     sense,
  output cse_pkg::cse_com_t       com_mode,
  output logic                    halted,
  output logic                    reduce_sens,
  output logic [1:0]              tune_coarse,
  output logic [3:0]              tune_fine,
  output logic [7:0]              tune_comp,
  output logic [1:0]              scan_period,
  output logic                    idle_scan
);
  import cse_pkg::*;
  localparam int SIG_HALF = `CSE_SIG_HALF_MS * TICK_CYC;
  typedef struct packed {
    cse_sensitivity_scan_config_bank_t  sensitivity_scan_config_bank;
    cse_com_t    com;
    cse_meas_t   meas;
    logic [15:0] collect;
    logic [15:0] xfers;
    cse_sense_t  sn;
    logic        halt;
    logic        act_saved;
    logic        act_restore;
    logic        act;
    logic        reduce;
    logic [1:0]  coarse;
    logic [3:0]  fine;
    logic [7:0]  comp;
    logic [7:0]  samp;
    logic [2:0]  sig_cnt;
    logic [31:0] sig_tmr;
    logic        sig_lvl;
    logic        clk_lvl;
    logic        idle;
    logic [7:0]  rdata;
    logic        pin_low_s;
  } cse_state_t;
  cse_state_t st_reg;
  cse_state_t st_next;
  logic pin_in_sel;
  logic sample_en;
  logic act_slot;
  logic short_pulse;
  logic halt_enter;
  logic halt_release;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] cse_sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    cse_sat_add = s[8] ? 8'hFF : s[7:0];
  endfunction : cse_sat_add
  function automatic logic [15:0] cse_absdiff(input logic [15:0] a, input logic [15:0] b);
    cse_absdiff = (a > b) ? a - b : b - a;
  endfunction : cse_absdiff
  // ---------------------------------------------------------------
  // input pin selection and sampling
  // ---------------------------------------------------------------
  always_comb
  begin
    pin_in_sel = 1'b0;
    sample_en  = 1'b0;
    act_slot   = 1'b0;
    if (ui_sel == CSE_UI_ACTIVATION_MOVEMENT_INTERFACE && input_feature_en)
    begin
      // pin is only released in a slot; the level read there is held until the next
      act_slot   = (st_reg.samp == 8'h00) || st_reg.halt;
      pin_in_sel = act_slot ? !activation_output_in : st_reg.pin_low_s;
      sample_en  = 1'b1;
    end
    else if (ui_sel == CSE_UI_MOVEMENT_INPUT_INTERFACE)
    begin
      pin_in_sel = !multifunction_pin_in;
      sample_en  = 1'b1;
    end
  end
  cse_pulse_timer #(
    .TICK_CYC     (TICK_CYC)
  ) u_timer (
    .mclk         (mclk),
    .rst          (rst),
    .pin_low      (pin_in_sel),
    .sample_en    (sample_en || !pin_in_sel),
    .short_pulse  (short_pulse),
    .halt_enter   (halt_enter),
    .halt_release (halt_release)
  );
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic reduce_req;
    logic soft_rst;
    logic [15:0] diff;
    reduce_req = ui_sel == CSE_UI_MOVEMENT_INPUT_INTERFACE && input_is_reduce;
    soft_rst   = halt_release;
    diff       = '0;
    st_next    = st_reg;
    st_next.samp = (st_reg.samp == 8'(SAMPLE_PERIOD - 1)) ? 8'h00 : st_reg.samp + 8'h01;
    st_next.pin_low_s = pin_in_sel && ui_sel == CSE_UI_ACTIVATION_MOVEMENT_INTERFACE;
    // configuration write, always reachable while in polling mode
    if (cfg_wr && st_reg.com == CSE_COM_I2C)
      st_next.sensitivity_scan_config_bank = cfg_wdata;
    st_next.rdata = st_reg.sensitivity_scan_config_bank;
    // mode handoff
    if (cfg_switch_en && i2c_window_close && st_reg.com == CSE_COM_I2C)
      st_next.com = com_target;
    // short pulses
    if (short_pulse)
    begin
      if (reduce_req)
        st_next.reduce = !st_reg.reduce;
      else
        st_next.sn.long_term_average = st_reg.sn.counts;
    end
    // thresholds with optional reduction
    st_next.sn.prox_th   = st_reg.reduce ? cse_sat_add(prox_th_cfg, 8'(`CSE_PROX_ADD))
                                         : prox_th_cfg;
    st_next.sn.act_th    = st_reg.reduce ? cse_sat_add(act_th_cfg, 8'(`CSE_ACT_ADD))
                                         : act_th_cfg;
    st_next.sn.mov_th    = mov_th_cfg;
    st_next.sn.ac_double = st_reg.reduce;
    // halt and soft reset
    if (halt_enter && !reduce_req)
    begin
      st_next.halt      = 1'b1;
      st_next.act_saved = st_reg.act;
      st_next.meas      = CSE_M_IDLE;
    end
    if (soft_rst && st_reg.halt)
    begin
      st_next.halt        = 1'b0;
      st_next.act         = st_reg.act_saved;
      st_next.act_restore = 1'b1;
      st_next.coarse      = '0;
      st_next.fine        = '0;
      st_next.comp        = '0;
      st_next.sig_cnt     = 3'(`CSE_SIG_PULSES * 2);
      st_next.sig_tmr     = '0;
    end
    // measurement by charge transfer
    if (!st_reg.halt)
    begin
      unique case (st_reg.meas)
        CSE_M_IDLE:
        begin
          st_next.collect = '0;
          st_next.xfers   = '0;
          st_next.meas    = CSE_M_XFER;
        end
        CSE_M_XFER:
        begin
          st_next.collect = st_reg.collect + transfer_charge + 16'({st_reg.comp, 8'h00} >> 8);
          st_next.xfers   = st_reg.xfers + 16'h0001;
          if (st_next.collect >= `CSE_CAP_TRIP)
            st_next.meas = CSE_M_DONE;
        end
        CSE_M_DONE:
        begin
          st_next.sn.counts = st_reg.xfers;
          st_next.meas      = CSE_M_IDLE;
          // recalibration after soft reset clears restored state
          if (st_reg.act_restore)
          begin
            st_next.sn.long_term_average      = st_reg.xfers;
            st_next.act_restore = 1'b0;
            st_next.act_saved   = 1'b0;
          end
          // tuning: the multiplier loads base_sel in both modes; partial mode keeps fine fixed
          if (!partial_tune_en)
            st_next.coarse = st_reg.sensitivity_scan_config_bank.base_sel;
          else
            st_next.coarse = st_reg.sensitivity_scan_config_bank.base_sel;
          // compensation adds charge per transfer, so more of it lowers the counts
          if (st_reg.xfers > tune_target && st_reg.comp != 8'hFF)
            st_next.comp = st_reg.comp + 8'h01;
          else if (st_reg.xfers < tune_target && st_reg.comp != 8'h00)
            st_next.comp = st_reg.comp - 8'h01;
          else if (!partial_tune_en && st_reg.comp == 8'hFF && st_reg.fine != 4'hF)
            st_next.fine = st_reg.fine + 4'h1;
          // scan direction
          diff = cse_absdiff(st_reg.xfers, st_reg.sn.long_term_average);
          if (activation_det)
            st_next.idle = 1'b1;
          else if (st_reg.sensitivity_scan_config_bank.wake_both && diff > {8'h00, st_reg.sn.prox_th})
            st_next.idle = 1'b1;
          else
            st_next.idle = 1'b0;
        end
        default:
          st_next.meas = CSE_M_IDLE;
      endcase
      if (!st_reg.act_restore)
        st_next.act = activation_det;
    end
    // signature pulses after any reset
    if (st_reg.sig_cnt != 3'd0)
    begin
      if (st_reg.sig_tmr == 32'(SIG_HALF - 1))
      begin
        st_next.sig_tmr = '0;
        st_next.sig_lvl = !st_reg.sig_lvl;
        st_next.sig_cnt = st_reg.sig_cnt - 3'd1;
      end
      else
        st_next.sig_tmr = st_reg.sig_tmr + 32'h1;
    end
    else
      st_next.sig_lvl = 1'b0;
    // event clock for streaming
    if (st_reg.com == CSE_COM_STREAM && event_active)
      st_next.clk_lvl = !st_reg.clk_lvl;
  end
  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_reg         <= '0;
      st_reg.sensitivity_scan_config_bank   <= `CSE_SENSITIVITY_SCAN_CONFIG_BANK_RST;
      st_reg.sig_cnt <= 3'(`CSE_SIG_PULSES * 2);
    end
    else
      st_reg <= st_next;
  end
  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      activation_output     <= 1'b0;
      activation_output_oe  <= 1'b0;
      multifunction_pin_out <= 1'b0;
      multifunction_pin_oe  <= 1'b0;
      cfg_rdata             <= 8'h00;
      sense                 <= '0;
      com_mode              <= CSE_COM_I2C;
      halted                <= 1'b0;
      reduce_sens           <= 1'b0;
      tune_coarse           <= 2'h0;
      tune_fine             <= 4'h0;
      tune_comp             <= 8'h00;
      scan_period           <= 2'h0;
      idle_scan             <= 1'b0;
    end
    else
    begin
      // pins pulse together during signature, else follow mode
      activation_output     <= (st_next.sig_cnt != 3'd0) ? st_next.sig_lvl :
                               (st_next.com == CSE_COM_STREAM) ? stream_bit : st_next.act;
      activation_output_oe  <= !(ui_sel == CSE_UI_ACTIVATION_MOVEMENT_INTERFACE && input_feature_en
                                 && (st_next.samp == 8'h00 || st_next.halt));
      multifunction_pin_out <= (st_next.sig_cnt != 3'd0) ? st_next.sig_lvl :
                               (st_next.com == CSE_COM_STREAM) ? st_next.clk_lvl : 1'b0;
      multifunction_pin_oe  <= ui_sel != CSE_UI_MOVEMENT_INPUT_INTERFACE;
      cfg_rdata             <= st_next.rdata;
      sense                 <= st_next.sn;
      com_mode              <= st_next.com;
      halted                <= st_next.halt;
      reduce_sens           <= st_next.reduce;
      tune_coarse           <= st_next.coarse;
      tune_fine             <= st_next.fine;
      tune_comp             <= st_next.comp;
      scan_period           <= st_next.sensitivity_scan_config_bank.scan_sel;
      idle_scan             <= st_next.idle;
    end
  end
endmodule : cse_ext_ctrl
`default_nettype wire

//--- bench/cse_ext_ctrl_asserts.sv
// checker for the capacitive sense external-control block
`timescale 1ns/1ps
`default_nettype none
`include "cse_defs.svh"
module cse_ext_ctrl_chk
  import cse_pkg::*;
#(
  parameter int TICK_CYC = 10
) (
  // clock and reset
  input wire logic                mclk,
  input wire logic                rst,
  // configuration
  input wire cse_pkg::cse_ui_t    ui_sel,
  input wire cse_pkg::cse_com_t   com_target,
  input wire logic                cfg_switch_en,
  input wire logic                input_is_reduce,
  input wire logic [7:0]          prox_th_cfg,
  input wire logic [7:0]          act_th_cfg,
  input wire logic [7:0]          mov_th_cfg,
  input wire logic                cfg_wr,
  input wire logic [7:0]          cfg_wdata,
  input wire logic [7:0]          cfg_rdata,
  input wire logic                i2c_window_close,
  // pins and status
  input wire logic                multifunction_pin_in,
  input wire logic                activation_output,
  input wire cse_pkg::cse_sense_t sense,
  input wire cse_pkg::cse_com_t   com_mode,
  input wire logic                halted,
  input wire logic                reduce_sens,
  input wire logic [1:0]          scan_period
);
  localparam int T = TICK_CYC;
  localparam int SIG_WIN = 3 * TICK_CYC;
  logic [15:0] low_cnt_reg;
  logic [7:0]  wd_reg;
  logic [1:0]  age_reg;
  logic        rel;
  logic        mov;
  logic        short_rel;
  // -----------------------------------------------
  // helper: low-time counter and last accepted write
  // -----------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      low_cnt_reg <= 16'h0000;
      wd_reg      <= `CSE_SENSITIVITY_SCAN_CONFIG_BANK_RST;
      age_reg     <= 2'h0;
    end
    else
    begin
      low_cnt_reg <= multifunction_pin_in ? 16'h0000 : low_cnt_reg + 16'h0001;
      if (cfg_wr && com_mode == CSE_COM_I2C)
        wd_reg <= cfg_wdata;
      if (age_reg != 2'h3)
        age_reg <= age_reg + 2'h1;
    end
  end
  assign rel = multifunction_pin_in && low_cnt_reg != 16'h0000;
  assign mov = ui_sel == CSE_UI_MOVEMENT_INPUT_INTERFACE;
  assign short_rel = rel && mov && low_cnt_reg >= 17 * T && low_cnt_reg <= 24 * T;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // -----------------------------------------------
  // assertions
  // -----------------------------------------------
  chk_reseed_lta: assert property (short_rel && !input_is_reduce |-> ##[1:5] sense.long_term_average == sense.counts)
    else $error("reference not reseeded after short pulse");
  chk_reduce_set: assert property (short_rel && input_is_reduce && !reduce_sens |-> ##[1:5] reduce_sens)
    else $error("reduce request not taken");
  chk_reduce_thr: assert property (age_reg == 2'h3 && reduce_sens && $past(reduce_sens, 2)
    |-> sense.prox_th == prox_th_cfg + 8'h04 && sense.act_th == act_th_cfg + 8'h0A
    && sense.mov_th == mov_th_cfg && sense.ac_double)
    else $error("reduced thresholds wrong");
  chk_halt_entry: assert property (mov && low_cnt_reg == 51 * T |-> ##[0:4] halted)
    else $error("halt not entered");
  chk_halt_early: assert property (mov && $rose(halted) |-> low_cnt_reg >= 49 * T)
    else $error("halt entered too early");
  chk_halt_release: assert property (mov && halted && rel |-> ##[1:5] !halted)
    else $error("no soft reset on release");
  chk_ignore_mid: assert property (mov && rel && low_cnt_reg >= 26 * T && low_cnt_reg <= 48 * T
    |-> ##1 ($stable(reduce_sens) && !halted) [*6])
    else $error("mid-length pulse acted on");
  chk_cfg_write: assert property (cfg_wr && com_mode == CSE_COM_I2C |-> ##[1:3] cfg_rdata == wd_reg)
    else $error("bank write not read back");
  chk_scan_field: assert property (age_reg == 2'h3 |-> scan_period == wd_reg[5:4])
    else $error("scan period field mismatch");
  chk_mode_switch: assert property (i2c_window_close && cfg_switch_en && com_mode == CSE_COM_I2C
    |-> ##[1:3] com_mode == com_target)
    else $error("mode not switched at window close");
  chk_signature: assert property (age_reg == 2'h1 |-> ##[0:SIG_WIN] activation_output)
    else $error("no signature pulse after reset");
  cov_reseed: cover property (short_rel && !input_is_reduce);
  cov_halt: cover property ($rose(halted));
  cov_switch: cover property (i2c_window_close && cfg_switch_en);
endmodule : cse_ext_ctrl_chk
bind cse_ext_ctrl cse_ext_ctrl_chk #(.TICK_CYC(TICK_CYC)) chk_u (.mclk(mclk), .rst(rst),
  .ui_sel(ui_sel), .com_target(com_target), .cfg_switch_en(cfg_switch_en),
  .input_is_reduce(input_is_reduce), .prox_th_cfg(prox_th_cfg), .act_th_cfg(act_th_cfg),
  .mov_th_cfg(mov_th_cfg), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .i2c_window_close(i2c_window_close), .multifunction_pin_in(multifunction_pin_in),
  .activation_output(activation_output), .sense(sense), .com_mode(com_mode),
  .halted(halted), .reduce_sens(reduce_sens), .scan_period(scan_period));
`default_nettype wire

//--- bench/cse_host_model.sv
// host controller model pulsing the multifunction line or the activation line
`timescale 1ns/1ps
`default_nettype none
module cse_host_model #(
  parameter int GAP = 300
) (
  // clock
  input  wire logic mclk,
  // line drive
  output logic      host_low
);
  initial host_low = 1'b0;
  // line is only pulled low by the host; otherwise it is released and left to the pull-up
  task automatic low_pulse(input int cyc, input logic twice);
    repeat (twice ? 2 : 1)
    begin
      host_low = 1'b1;
      repeat (cyc) @(posedge mclk);
      #1;
      host_low = 1'b0;
      repeat (GAP) @(posedge mclk);
      #1;
    end
  endtask : low_pulse
endmodule : cse_host_model
`default_nettype wire

//--- bench/testbench.sv
// self-checking testbench for the external-control block
`timescale 1ns/1ps
`default_nettype none
`include "cse_defs.svh"
module testbench;
  import cse_pkg::*;
  localparam int TK = 10;
  logic mclk, rst, cfg_switch_en, input_feature_en, input_is_reduce, partial_tune_en;
  logic cfg_wr, i2c_window_close, activation_det, event_active, stream_bit, use_act;
  cse_ui_t ui_sel;
  cse_com_t com_target, com_mode;
  logic [15:0] tune_target, transfer_charge;
  logic [7:0] prox_th_cfg, act_th_cfg, mov_th_cfg, cfg_wdata, cfg_rdata, v;
  wire logic mf_in, act_in, act_out, act_oe, mf_out, mf_oe, host_low;
  cse_sense_t sense;
  logic halted, reduce_sens, idle_scan;
  logic [1:0] scan_period, coarse;
  int miscompares, total_checks, cyc_cnt, c;
  int lens[4] = '{20, 13, 30, 20};
  logic rexp[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  // line levels: device drive wins on the multifunction line, host low wins on the activation line, pull-up otherwise
  assign mf_in = mf_oe ? mf_out : (use_act | ~host_low);
  assign act_in = (act_oe ? act_out : 1'b1) & ~(use_act & host_low);
  cse_ext_ctrl #(.TICK_CYC(TK), .SAMPLE_PERIOD(4)) dut_u (.mclk(mclk), .rst(rst),
    .ui_sel(ui_sel), .com_target(com_target), .cfg_switch_en(cfg_switch_en),
    .input_feature_en(input_feature_en), .input_is_reduce(input_is_reduce),
    .partial_tune_en(partial_tune_en), .tune_target(tune_target), .prox_th_cfg(prox_th_cfg),
    .act_th_cfg(act_th_cfg), .mov_th_cfg(mov_th_cfg), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .i2c_window_close(i2c_window_close), .multifunction_pin_in(mf_in),
    .activation_output_in(act_in), .activation_output(act_out), .activation_output_oe(act_oe),
    .multifunction_pin_out(mf_out), .multifunction_pin_oe(mf_oe),
    .activation_det(activation_det), .event_active(event_active), .stream_bit(stream_bit),
    .transfer_charge(transfer_charge), .sense(sense), .com_mode(com_mode), .halted(halted),
    .reduce_sens(reduce_sens), .tune_coarse(coarse), .tune_fine(), .tune_comp(),
    .scan_period(scan_period), .idle_scan(idle_scan));
  cse_host_model host_u (.mclk(mclk), .host_low(host_low));
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // -----------------------------------------------
  // tasks and expectations
  // -----------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  function automatic logic [15:0] exp_counts(input logic [15:0] q);
    return (`CSE_CAP_TRIP + q - 16'h0001) / q;
  endfunction : exp_counts
  task automatic do_reset;
    rst = 1'b1;
    step(12);
    rst = 1'b0;
  endtask : do_reset
  task automatic wr_cfg(input logic [7:0] d);
    cfg_wdata = d;
    cfg_wr = 1'b1;
    step(1);
    cfg_wr = 1'b0;
    step(3);
  endtask : wr_cfg
  task automatic count_chg(input logic pick, input int n, output int cnt);
    logic p;
    cnt = 0;
    p = pick ? mf_out : act_out;
    repeat (n)
    begin
      stream_bit = 1'($urandom);
      step(1);
      if ((pick ? mf_out : act_out) !== p)
        cnt++;
      p = pick ? mf_out : act_out;
    end
  endtask : count_chg
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  always @(posedge mclk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 30000)
    begin
      miscompares++;
      report_and_stop;
    end
  end
  // -----------------------------------------------
  // main sequence
  // -----------------------------------------------
  initial
  begin
    void'($urandom(14850));
    {rst, cfg_switch_en, input_feature_en, input_is_reduce, cfg_wr} = 5'h10;
    {i2c_window_close, activation_det, event_active, stream_bit, use_act} = 5'h00;
    partial_tune_en = 1'b1;
    ui_sel = CSE_UI_MOVEMENT_INPUT_INTERFACE;
    com_target = CSE_COM_STREAM;
    tune_target = 16'($urandom_range(1600, 400));
    transfer_charge = 16'($urandom_range(1023, 64));
    prox_th_cfg = 8'($urandom_range(200, 1));
    act_th_cfg = 8'($urandom_range(200, 1));
    mov_th_cfg = 8'($urandom_range(200, 1));
    cfg_wdata = 8'h00;
    do_reset;
    chk_val(16'(cfg_rdata), 16'(`CSE_SENSITIVITY_SCAN_CONFIG_BANK_RST));
    count_chg(1'b0, 15 * TK, c);
    chk_val(16'(c), 16'h0006);
    $display("test signature done");
    for (int i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      wr_cfg(v);
      chk_val(16'(cfg_rdata), 16'(v));
      chk_val(16'(scan_period), 16'(v[5:4]));
    end
    $display("test bank done");
    transfer_charge = 16'($urandom_range(1023, 64));
    step(200);
    host_u.low_pulse(20 * TK, 1'b0);
    chk_val(sense.counts, exp_counts(transfer_charge));
    chk_val(sense.long_term_average, exp_counts(transfer_charge));
    chk_val(16'(coarse), 16'(v[7:6]));
    $display("test reseed done");
    input_is_reduce = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      host_u.low_pulse(lens[i] * TK, 1'b0);
      chk_bit(reduce_sens, rexp[i]);
      chk_val(16'(sense.prox_th), 16'(prox_th_cfg) + (rexp[i] ? 16'h0004 : 16'h0000));
    end
    chk_val(16'(sense.prox_th), 16'(prox_th_cfg));
    $display("test reduce done");
    input_is_reduce = 1'b0;
    activation_det = 1'b1;
    fork
      host_u.low_pulse(60 * TK, 1'b1);
      begin
        step(58 * TK);
        chk_bit(halted, 1'b1);
        step(5 * TK);
        chk_bit(halted, 1'b0);
      end
    join
    chk_bit(idle_scan, 1'b1);
    $display("test halt done");
    ui_sel = CSE_UI_ACTIVATION_MOVEMENT_INTERFACE;
    {input_feature_en, use_act} = 2'h3;
    fork
      host_u.low_pulse(60 * TK, 1'b0);
      begin
        step(58 * TK);
        chk_bit(halted, 1'b1);
      end
    join
    ui_sel = CSE_UI_MOVEMENT_INPUT_INTERFACE;
    {input_feature_en, use_act} = 2'h0;
    $display("test input sampling done");
    cfg_switch_en = 1'b1;
    i2c_window_close = 1'b1;
    step(1);
    i2c_window_close = 1'b0;
    step(3);
    chk_val(16'(com_mode), 16'(CSE_COM_STREAM));
    v = cfg_rdata;
    wr_cfg(~v);
    chk_val(16'(cfg_rdata), 16'(v));
    count_chg(1'b1, 100, c);
    chk_val(16'(c), 16'h0000);
    event_active = 1'b1;
    count_chg(1'b1, 100, c);
    chk_bit(c != 0, 1'b1);
    chk_bit(act_out, stream_bit);
    $display("test stream done");
    activation_det = 1'b0;
    do_reset;
    chk_val(16'(com_mode), 16'(CSE_COM_I2C));
    count_chg(1'b0, 15 * TK, c);
    chk_val(16'(c), 16'h0006);
    wr_cfg(v);
    chk_val(16'(cfg_rdata), 16'(v));
    $display("test second reset done");
    report_and_stop;
  end
endmodule : testbench
`default_nettype wire
